// ==== rtl/sbcrg_pkg.sv ====
package sbcrg_pkg;
    // ------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_HW_CTRL_ZERO = 7'h02;

    localparam logic [7:0] MS_POR_VALUE = 8'h00;
    localparam logic [7:0] HW_POR_VALUE = 8'h00;
    localparam logic [7:0] MS_WRITE_MASK = 8'hdf;
    localparam logic [7:0] HW_WRITE_MASK = 8'h65;
    localparam logic [7:0] MS_RESTART_KEEP = 8'h03;
    localparam logic [7:0] HW_RESTART_KEEP = 8'h45;

    localparam int MS_MODE_LSB = 6;
    localparam int MS_AUX_LSB = 3;
    localparam int MS_OV_RESTART_BIT = 2;
    localparam int MS_THRESH_LSB = 0;
    localparam int HW_SOFT_PIN_BIT = 6;
    localparam int HW_FORCE_BIT = 5;
    localparam int HW_CP_BIT = 2;
    localparam int HW_WD_SEL_BIT = 0;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_SOFT_RESET = 2'h3;

    localparam logic [1:0] AUX_OFF = 2'h0;
    localparam logic [1:0] AUX_ON_NORMAL = 2'h1;
    localparam logic [1:0] AUX_ON_NORMAL_STOP = 2'h2;
    localparam logic [1:0] AUX_ALWAYS_ON = 2'h3;
    localparam logic [1:0] AUX_DEV_POR_VALUE = 2'h3;

    localparam logic [1:0] WD_FAIL_ONE = 2'h1;
    localparam logic [1:0] WD_FAIL_TWO = 2'h2;

    // Strap sampled once both synchroniser stages are loaded
    localparam logic [1:0] INIT_APPLY_COUNT = 2'h2;
    localparam logic [1:0] INIT_DONE_COUNT = 2'h3;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_SLEEP = 3'b010,
        ST_STOP = 3'b100
    } sbcrg_state_type;
endpackage : sbcrg_pkg

// ==== rtl/sbcrg_fo_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sbcrg_fo_if;
    logic force_req;
    logic pin_is_fail_out;
    logic failure_active;
    logic fail_output;

    modport ctrl (output force_req, output pin_is_fail_out, output failure_active, input fail_output);
    modport drv (input force_req, input pin_is_fail_out, input failure_active, output fail_output);
endinterface : sbcrg_fo_if
`default_nettype wire

// ==== rtl/sbcrg_fail_out.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbcrg_fail_out
    import sbcrg_pkg::*;
(
    input wire logic core_clk_i, // System clock
    input wire logic rst_b_i,    // Async reset, active low
    sbcrg_fo_if.drv fo           // Fail output request and result
);
    typedef struct packed {
        logic fail_out;
    } sbcrg_fo_state_type;

    sbcrg_fo_state_type s_q;
    sbcrg_fo_state_type s_d;

    // ------------------------------------------------------------
    // Fail output combine
    // ------------------------------------------------------------
    // Failure term stands alone so dropping the force never releases it
    always_comb begin
        s_d = s_q;
        s_d.fail_out = fo.failure_active | (fo.force_req & fo.pin_is_fail_out); // RULE13 RULE14
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fo.fail_output = s_q.fail_out;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_FO_FAILURE_HOLDS: assert property (fo.failure_active |=> fo.fail_output) // RULE14
        else $error("fail output released while failure active");
    AST_FO_FORCE: assert property (fo.force_req && fo.pin_is_fail_out |=> fo.fail_output) // RULE13
        else $error("software force did not raise fail output");
    AST_FO_IDLE: assert property (!fo.failure_active && !(fo.force_req && fo.pin_is_fail_out)
        |=> !fo.fail_output) // RULE13
        else $error("fail output active without cause");
endmodule : sbcrg_fail_out
`default_nettype wire

// ==== rtl/sbcrg_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Mode field selects normal, sleep, stop, soft reset
// RULE2: Stop never goes directly to sleep
// RULE3: Stop to normal ignores bits 4:0, flags error
// RULE4: Restart rewrites mode field to normal
// RULE5: Restart or overtemperature switches auxiliary supply off
// RULE6: Auxiliary supply mode field encodes four modes
// RULE7: Write returns the previously programmed content
// RULE8: Development mode powers up auxiliary supply on
// RULE9: Overvoltage sets flag; restart only if enabled
// RULE10: Threshold field selects one of four thresholds
// RULE11: Reserved bits always read zero
// RULE12: Soft-reset pin bit gates reset output pulse
// RULE13: Force bit drives fail output if configured
// RULE14: Only clearing failure releases failure-driven output
// RULE15: Restart clears force bit, releases forced output
// RULE16: Charge-pump bit switches charge-pump output
// RULE17: Watchdog select picks first or second failure
// RULE18: Soft reset keeps locked bits, else power-on
// RULE19: Restart clears mode register except threshold
// RULE20: Restart keeps hardware bits 6, 2, 0
// RULE21: Command bit 7 selects write or read
// RULE22: Locked bits refuse writes while lock set
// RULE23: Every register update lands whole per byte
module sbcrg_regs
    import sbcrg_pkg::*;
#(
    parameter int RST_LOW_CYCLES = 16 // Reset output low time after soft reset
) (
    input wire logic core_clk_i,              // System clock, 50 MHz
    input wire logic rst_b_i,                 // Power-on reset, async, active low
    input wire logic cmd_valid_i,             // One command byte pair present
    input wire logic cmd_write_i,             // Command bit 7: 1 write, 0 read
    input wire logic [6:0] cmd_addr_i,        // Register address
    input wire logic [7:0] cmd_data_i,        // Write data byte
    output logic rsp_valid_o,                 // Response byte valid, one cycle
    output logic [7:0] rsp_data_o,            // Content before the command
    output logic spi_error_o,                 // Pulse: ignored stop-to-normal change
    input wire logic dev_mode_pin_i,          // Development mode strap pin
    input wire logic init_mode_i,             // Device in init mode
    input wire logic restart_mode_i,          // Device in restart mode
    input wire logic failsafe_mode_i,         // Device in fail-safe mode
    input wire logic overtemp_i,              // Pulse: overtemperature event
    input wire logic main_ov_i,               // Pulse: main supply overvoltage
    input wire logic ov_flag_clr_i,           // Pulse: clear overvoltage flag
    input wire logic wd_trig_fail_i,          // Pulse: watchdog trigger failure
    input wire logic lock_zero_i,             // Lock zero set
    input wire logic lock_one_i,              // Lock one set
    input wire logic fail_pin_cfg_i,          // Pin configured as fail output
    input wire logic failure_active_i,        // Failure flag holding fail output
    output logic [2:0] sbc_mode_o,            // One-hot normal, sleep, stop
    output logic soft_reset_o,                // Pulse: soft reset executed
    output logic reset_output_n_o,            // Reset output, active low
    output logic [1:0] aux_supply_mode_o,     // Auxiliary supply mode field
    output logic aux_supply_on_o,             // Auxiliary supply enabled
    output logic main_overvoltage_flag_o,     // Sticky overvoltage flag
    output logic main_ov_escalate_o,          // Pulse: overvoltage restart request
    output logic [1:0] main_reset_threshold_o,// Reset threshold select
    output logic charge_pump_o,               // Charge pump enable
    output logic wd_escalate_o,               // Pulse: watchdog restart request
    output logic fail_output_o                // Fail output, active high
);
    localparam int CNT_W = $clog2(RST_LOW_CYCLES + 1);

    if (RST_LOW_CYCLES < 1) begin : g_bad_rst_low
        $error("RST_LOW_CYCLES must be at least one");
    end

    typedef struct packed {
        logic [7:0] ms;
        logic [7:0] hw;
        sbcrg_state_type st;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic spi_err;
        logic ov_flag;
        logic ov_esc;
        logic [1:0] wd_cnt;
        logic wd_esc;
        logic [CNT_W-1:0] rst_cnt;
        logic rst_n;
        logic soft_pulse;
        logic aux_on;
        logic restart_prev;
        logic [1:0] init_cnt;
        logic dev_s1;
        logic dev_s2;
    } sbcrg_regs_state_type;

    sbcrg_regs_state_type s_q;
    sbcrg_regs_state_type s_d;

    logic wr_ms;
    logic wr_hw;
    logic soft_cmd;
    logic restart_entry;
    logic [7:0] ms_wdata;
    logic [1:0] wr_mode;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign wr_ms = cmd_valid_i & cmd_write_i & (cmd_addr_i == ADDR_MODE_SUPPLY); // RULE21
    assign wr_hw = cmd_valid_i & cmd_write_i & (cmd_addr_i == ADDR_HW_CTRL_ZERO); // RULE21
    assign ms_wdata = cmd_data_i & MS_WRITE_MASK; // RULE11
    assign wr_mode = ms_wdata[MS_MODE_LSB +: 2];
    assign soft_cmd = wr_ms & (wr_mode == MODE_SOFT_RESET); // RULE1
    // Restart is level from the mode logic; act once on its rising edge
    assign restart_entry = restart_mode_i & ~s_q.restart_prev;

    sbcrg_fo_if fo_bus ();

    assign fo_bus.force_req = s_q.hw[HW_FORCE_BIT];
    assign fo_bus.pin_is_fail_out = fail_pin_cfg_i;
    assign fo_bus.failure_active = failure_active_i;

    sbcrg_fail_out u_fail_out (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .fo(fo_bus.drv)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // All updates build s_d and land in one edge, so a read sees whole bytes
    always_comb begin // RULE23
        s_d = s_q;
        s_d.dev_s1 = dev_mode_pin_i;
        s_d.dev_s2 = s_q.dev_s1;
        s_d.restart_prev = restart_mode_i;
        s_d.rsp_valid = 1'b0;
        s_d.spi_err = 1'b0;
        s_d.ov_esc = 1'b0;
        s_d.wd_esc = 1'b0;
        s_d.soft_pulse = 1'b0;

        if (s_q.init_cnt != INIT_DONE_COUNT) begin
            s_d.init_cnt = s_q.init_cnt + 2'h1;
        end
        if (s_q.init_cnt == INIT_APPLY_COUNT && s_q.dev_s2) begin
            s_d.ms[MS_AUX_LSB +: 2] = AUX_DEV_POR_VALUE; // RULE8
        end

        if (s_q.rst_cnt != '0) begin
            s_d.rst_cnt = s_q.rst_cnt - CNT_W'(1);
        end

        if (cmd_valid_i) begin
            s_d.rsp_valid = 1'b1;
            if (cmd_addr_i == ADDR_MODE_SUPPLY) begin
                s_d.rsp_data = s_q.ms; // RULE7
            end else if (cmd_addr_i == ADDR_HW_CTRL_ZERO) begin
                s_d.rsp_data = s_q.hw; // RULE7
            end else begin
                s_d.rsp_data = 8'h00;
            end
        end

        if (soft_cmd) begin
            // Soft reset switches the auxiliary supply off even in development mode
            s_d.ms = MS_POR_VALUE; // RULE8 RULE18
            s_d.hw = HW_POR_VALUE; // RULE18
            if (lock_one_i) begin
                s_d.hw[HW_SOFT_PIN_BIT] = s_q.hw[HW_SOFT_PIN_BIT]; // RULE18
            end
            if (lock_zero_i) begin
                s_d.hw[HW_CP_BIT] = s_q.hw[HW_CP_BIT]; // RULE18
            end
            s_d.st = ST_NORMAL;
            s_d.wd_cnt = 2'h0;
            s_d.soft_pulse = 1'b1;
            if (!s_q.hw[HW_SOFT_PIN_BIT]) begin
                s_d.rst_cnt = CNT_W'(RST_LOW_CYCLES); // RULE12
            end
        end else if (wr_ms) begin
            if (s_q.st == ST_STOP && wr_mode == MODE_SLEEP) begin
                s_d.ms = {s_q.ms[7:6], 1'b0, ms_wdata[4:0]}; // RULE2
            end else if (s_q.st == ST_STOP && wr_mode == MODE_NORMAL) begin
                s_d.ms = {MODE_NORMAL, s_q.ms[5:0]}; // RULE3
                s_d.st = ST_NORMAL; // RULE3
                s_d.spi_err = (ms_wdata[4:0] != s_q.ms[4:0]); // RULE3
            end else begin
                s_d.ms = ms_wdata; // RULE1 RULE6 RULE10
                case (wr_mode)
                    MODE_SLEEP: begin
                        s_d.st = ST_SLEEP; // RULE1
                    end
                    MODE_STOP: begin
                        s_d.st = ST_STOP; // RULE1
                    end
                    default: begin
                        s_d.st = ST_NORMAL; // RULE1
                    end
                endcase
            end
        end

        if (wr_hw) begin
            s_d.hw = cmd_data_i & HW_WRITE_MASK; // RULE11 RULE16 RULE17
            if (lock_one_i) begin
                s_d.hw[HW_SOFT_PIN_BIT] = s_q.hw[HW_SOFT_PIN_BIT]; // RULE22
            end
            if (lock_zero_i) begin
                s_d.hw[HW_CP_BIT] = s_q.hw[HW_CP_BIT]; // RULE22
            end
        end

        if (main_ov_i) begin
            s_d.ov_flag = 1'b1; // RULE9
            s_d.ov_esc = s_q.ms[MS_OV_RESTART_BIT]; // RULE9
        end else if (ov_flag_clr_i) begin
            s_d.ov_flag = 1'b0;
        end

        if (wd_trig_fail_i) begin
            if ((s_q.wd_cnt + 2'h1) >= (s_q.hw[HW_WD_SEL_BIT] ? WD_FAIL_ONE : WD_FAIL_TWO)) begin
                s_d.wd_esc = 1'b1; // RULE17
                s_d.wd_cnt = 2'h0;
            end else begin
                s_d.wd_cnt = s_q.wd_cnt + 2'h1;
            end
        end

        // Hardware clears win over a software write in the same cycle
        if (overtemp_i) begin
            s_d.ms[MS_AUX_LSB +: 2] = AUX_OFF; // RULE5
        end

        if (restart_entry) begin
            s_d.ms = s_d.ms & MS_RESTART_KEEP; // RULE4 RULE5 RULE19
            s_d.hw = s_d.hw & HW_RESTART_KEEP; // RULE15 RULE20
            s_d.st = ST_NORMAL; // RULE4
            s_d.wd_cnt = 2'h0;
        end

        s_d.rst_n = (s_d.rst_cnt == '0); // RULE12

        case (s_q.ms[MS_AUX_LSB +: 2])
            AUX_ON_NORMAL: begin
                s_d.aux_on = (s_q.st == ST_NORMAL) & ~restart_mode_i & ~failsafe_mode_i; // RULE6
            end
            AUX_ON_NORMAL_STOP: begin
                s_d.aux_on = (s_q.st != ST_SLEEP) & ~restart_mode_i & ~failsafe_mode_i; // RULE6
            end
            AUX_ALWAYS_ON: begin
                s_d.aux_on = ~restart_mode_i & ~failsafe_mode_i & ~(init_mode_i & ~s_q.dev_s2); // RULE6
            end
            default: begin
                s_d.aux_on = 1'b0; // RULE6
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
            s_q.st <= ST_NORMAL;
            s_q.rst_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rsp_valid_o = s_q.rsp_valid;
    assign rsp_data_o = s_q.rsp_data;
    assign spi_error_o = s_q.spi_err;
    assign sbc_mode_o = s_q.st;
    assign soft_reset_o = s_q.soft_pulse;
    assign reset_output_n_o = s_q.rst_n;
    assign aux_supply_mode_o = s_q.ms[MS_AUX_LSB +: 2];
    assign aux_supply_on_o = s_q.aux_on;
    assign main_overvoltage_flag_o = s_q.ov_flag;
    assign main_ov_escalate_o = s_q.ov_esc;
    assign main_reset_threshold_o = s_q.ms[MS_THRESH_LSB +: 2]; // RULE10
    assign charge_pump_o = s_q.hw[HW_CP_BIT]; // RULE16
    assign wd_escalate_o = s_q.wd_esc;
    assign fail_output_o = fo_bus.fail_output;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_RESERVED_ZERO: assert property ((s_q.ms & ~MS_WRITE_MASK) == 8'h00 && (s_q.hw & ~HW_WRITE_MASK) == 8'h00) // RULE11
        else $error("reserved bit reads nonzero");
    AST_READ_OLD: assert property (cmd_valid_i && cmd_addr_i == ADDR_MODE_SUPPLY
        |=> rsp_valid_o && rsp_data_o == $past(s_q.ms)) // RULE7
        else $error("response is not the previous content");
    AST_STOP_NO_SLEEP: assert property (wr_ms && s_q.st == ST_STOP && wr_mode == MODE_SLEEP && !restart_entry
        |=> sbc_mode_o == ST_STOP ##1 sbc_mode_o != ST_SLEEP) // RULE2
        else $error("stop moved straight to sleep");
    AST_STOP_TO_NORMAL: assert property (wr_ms && s_q.st == ST_STOP && wr_mode == MODE_NORMAL
        && !restart_entry && !overtemp_i
        |=> sbc_mode_o == ST_NORMAL && s_q.ms[4:0] == $past(s_q.ms[4:0])
        && spi_error_o == ($past(ms_wdata[4:0]) != $past(s_q.ms[4:0]))) // RULE3
        else $error("stop to normal write mishandled");
    AST_RESTART_VALUES: assert property (restart_entry && !cmd_valid_i
        |=> s_q.ms == ($past(s_q.ms) & MS_RESTART_KEEP) && s_q.hw == ($past(s_q.hw) & HW_RESTART_KEEP)
        && sbc_mode_o == ST_NORMAL) // RULE4 RULE15 RULE19 RULE20
        else $error("restart values wrong");
    AST_OVERTEMP_AUX: assert property (overtemp_i |=> aux_supply_mode_o == AUX_OFF) // RULE5
        else $error("overtemperature left auxiliary supply on");
    AST_OVERVOLTAGE: assert property (main_ov_i
        |=> main_overvoltage_flag_o && main_ov_escalate_o == $past(s_q.ms[MS_OV_RESTART_BIT])) // RULE9
        else $error("overvoltage reaction wrong");
    AST_SOFT_RESET_PIN: assert property (soft_cmd && !s_q.hw[HW_SOFT_PIN_BIT]
        |=> !reset_output_n_o && soft_reset_o) // RULE12
        else $error("soft reset did not pull reset output low");
    AST_SOFT_RESET_NO_PIN: assert property (soft_cmd && s_q.hw[HW_SOFT_PIN_BIT] && reset_output_n_o
        |=> reset_output_n_o) // RULE12
        else $error("reset output pulled with pin bit set");
    AST_LOCK_ZERO: assert property (wr_hw && lock_zero_i |=> charge_pump_o == $past(s_q.hw[HW_CP_BIT])) // RULE22
        else $error("locked charge pump bit changed");
    AST_SOFT_LOCK_ONE: assert property (soft_cmd && lock_one_i && !restart_entry
        |=> s_q.hw[HW_SOFT_PIN_BIT] == $past(s_q.hw[HW_SOFT_PIN_BIT])) // RULE18
        else $error("locked pin bit lost on soft reset");
    AST_WD_FIRST: assert property (wd_trig_fail_i && s_q.hw[HW_WD_SEL_BIT] |=> wd_escalate_o) // RULE17
        else $error("first watchdog failure not escalated");
    AST_WD_SECOND: assert property (wd_trig_fail_i && !s_q.hw[HW_WD_SEL_BIT] && s_q.wd_cnt == 2'h0
        |=> !wd_escalate_o) // RULE17
        else $error("first failure escalated with count two");
endmodule : sbcrg_regs
`default_nettype wire

// ==== sim/sbcrg_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbcrg_host_model (
    input wire logic clk_i, // Core clock
    input wire logic rsp_valid_i, // Response strobe
    input wire logic [7:0] rsp_data_i, // Response byte
    output logic cmd_valid_o, // Command strobe
    output logic cmd_write_o, // Access type
    output logic [6:0] cmd_addr_o, // Register address
    output logic [7:0] cmd_data_o // Data byte
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_addr_o = 7'h00;
        cmd_data_o = 8'h00;
    end

    // Released data flips so a stale byte is never mistaken for a valid one
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic ok);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= wr;
        cmd_addr_o <= a;
        cmd_data_o <= d;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_data_o <= ~d;
        #1;
        ok = rsp_valid_i;
        rd = rsp_data_i;
    endtask : xfer
endmodule : sbcrg_host_model
`default_nettype wire

// ==== sim/sbc_mode_hw_control_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbc_mode_hw_control_regs_tb_top;
    import sbcrg_pkg::*;
    logic core_clk, rst_b, cv, cw, rv, spi_err, dev_pin, init_m, rst_m, fs_m, ot, ov, ov_clr, wd;
    logic lock0, lock1, fpin, fail_act, srst, rst_n, aux_on, ov_flag, ov_esc, cp, wd_esc, fo;
    logic [6:0] ca;
    logic [7:0] cd, rd;
    logic [2:0] mode;
    logic [1:0] aux, thr;
    int errors;
    int total_checks;

    sbcrg_host_model u_host (.clk_i(core_clk), .rsp_valid_i(rv), .rsp_data_i(rd), .cmd_valid_o(cv),
        .cmd_write_o(cw), .cmd_addr_o(ca), .cmd_data_o(cd));

    sbcrg_regs #(.RST_LOW_CYCLES(2)) u_dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .cmd_valid_i(cv),
        .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_data_i(cd), .rsp_valid_o(rv), .rsp_data_o(rd),
        .spi_error_o(spi_err), .dev_mode_pin_i(dev_pin), .init_mode_i(init_m), .restart_mode_i(rst_m),
        .failsafe_mode_i(fs_m), .overtemp_i(ot), .main_ov_i(ov), .ov_flag_clr_i(ov_clr),
        .wd_trig_fail_i(wd), .lock_zero_i(lock0), .lock_one_i(lock1), .fail_pin_cfg_i(fpin),
        .failure_active_i(fail_act), .sbc_mode_o(mode), .soft_reset_o(srst), .reset_output_n_o(rst_n),
        .aux_supply_mode_o(aux), .aux_supply_on_o(aux_on), .main_overvoltage_flag_o(ov_flag),
        .main_ov_escalate_o(ov_esc), .main_reset_threshold_o(thr), .charge_pump_o(cp),
        .wd_escalate_o(wd_esc), .fail_output_o(fo));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
        logic [7:0] r;
        logic ok;
        u_host.xfer(w, a, d, r, ok);
        chk("rsp_valid", 8'h01, {7'h00, ok});
        chk("rsp_data", e, r);
    endtask : acc

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task automatic pulse(input int k);
        @(posedge core_clk);
        case (k)
            0: ov <= 1'b1;
            1: ov_clr <= 1'b1;
            2: wd <= 1'b1;
            default: ot <= 1'b1;
        endcase
        @(posedge core_clk);
        {ov, ov_clr, wd, ot} <= 4'h0;
        #1;
    endtask : pulse

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_write;
        chk("mode", 8'h01, {5'h00, mode});
        chk("reset_n", 8'h01, {7'h00, rst_n});
        acc(1'b1, 7'h01, 8'h2f, 8'h00);
        acc(1'b0, 7'h01, 8'hff, 8'h0f);
        acc(1'b0, 7'h01, 8'h00, 8'h0f);
        chk("threshold", 8'h03, {6'h00, thr});
        chk("aux_mode", 8'h01, {6'h00, aux});
        acc(1'b1, 7'h02, 8'hff, 8'h00);
        acc(1'b0, 7'h02, 8'h00, 8'h65);
        acc(1'b0, 7'h05, 8'h00, 8'h00);
        chk("charge_pump", 8'h01, {7'h00, cp});
        chk("fail_output", 8'h01, {7'h00, fo});
    endtask : t_write

    task automatic t_stop;
        acc(1'b1, 7'h01, 8'h8f, 8'h0f);
        chk("mode", 8'h04, {5'h00, mode});
        acc(1'b1, 7'h01, 8'h4f, 8'h8f);
        chk("mode", 8'h04, {5'h00, mode});
        acc(1'b1, 7'h01, 8'h00, 8'h8f);
        chk("spi_error", 8'h01, {7'h00, spi_err});
        chk("mode", 8'h01, {5'h00, mode});
        acc(1'b0, 7'h01, 8'h00, 8'h0f);
    endtask : t_stop

    task automatic t_ov;
        pulse(0);
        chk("ov_flag", 8'h01, {7'h00, ov_flag});
        chk("ov_esc", 8'h01, {7'h00, ov_esc});
        pulse(1);
        chk("ov_flag", 8'h00, {7'h00, ov_flag});
        acc(1'b1, 7'h01, 8'h0b, 8'h0f);
        pulse(0);
        chk("ov_flag", 8'h01, {7'h00, ov_flag});
        chk("ov_esc", 8'h00, {7'h00, ov_esc});
    endtask : t_ov

    task automatic t_restart;
        acc(1'b1, 7'h01, 8'h4b, 8'h0b);
        chk("mode", 8'h02, {5'h00, mode});
        @(posedge core_clk);
        rst_m <= 1'b1;
        step(3);
        chk("mode", 8'h01, {5'h00, mode});
        acc(1'b0, 7'h01, 8'h00, 8'h03);
        chk("aux_mode", 8'h00, {6'h00, aux});
        acc(1'b0, 7'h02, 8'h00, 8'h45);
        chk("fail_output", 8'h00, {7'h00, fo});
        @(posedge core_clk);
        rst_m <= 1'b0;
        acc(1'b1, 7'h02, 8'h44, 8'h45);
        pulse(2);
        chk("wd_esc", 8'h00, {7'h00, wd_esc});
        pulse(2);
        chk("wd_esc", 8'h01, {7'h00, wd_esc});
        acc(1'b1, 7'h02, 8'h45, 8'h44);
        pulse(2);
        chk("wd_esc", 8'h01, {7'h00, wd_esc});
    endtask : t_restart

    task automatic t_hold_ot;
        acc(1'b1, 7'h02, 8'h65, 8'h45);
        @(posedge core_clk);
        fail_act <= 1'b1;
        acc(1'b1, 7'h02, 8'h45, 8'h65);
        step(2);
        chk("fail_output", 8'h01, {7'h00, fo});
        @(posedge core_clk);
        fail_act <= 1'b0;
        step(2);
        chk("fail_output", 8'h00, {7'h00, fo});
        acc(1'b1, 7'h01, 8'h0b, 8'h03);
        step(1);
        chk("aux_on", 8'h01, {7'h00, aux_on});
        pulse(3);
        chk("aux_mode", 8'h00, {6'h00, aux});
        step(1);
        chk("aux_on", 8'h00, {7'h00, aux_on});
    endtask : t_hold_ot

    task automatic t_soft;
        @(posedge core_clk);
        lock0 <= 1'b1;
        acc(1'b1, 7'h02, 8'h40, 8'h45);
        acc(1'b0, 7'h02, 8'h00, 8'h44);
        acc(1'b1, 7'h01, 8'hc0, 8'h03);
        chk("soft_reset", 8'h01, {7'h00, srst});
        chk("reset_n", 8'h01, {7'h00, rst_n});
        acc(1'b0, 7'h01, 8'h00, 8'h00);
        acc(1'b0, 7'h02, 8'h00, 8'h04);
        acc(1'b1, 7'h01, 8'hc0, 8'h00);
        chk("reset_n", 8'h00, {7'h00, rst_n});
        step(1);
        chk("reset_n", 8'h00, {7'h00, rst_n});
        step(1);
        chk("reset_n", 8'h01, {7'h00, rst_n});
        @(posedge core_clk);
        lock0 <= 1'b0;
    endtask : t_soft

    // Second reset with the development strap, init and lock one
    task automatic t_dev;
        @(posedge core_clk);
        rst_b <= 1'b0;
        dev_pin <= 1'b1;
        init_m <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        step(4);
        chk("aux_mode", 8'h03, {6'h00, aux});
        chk("aux_on", 8'h01, {7'h00, aux_on});
        chk("mode", 8'h01, {5'h00, mode});
        @(posedge core_clk);
        fs_m <= 1'b1;
        step(1);
        chk("aux_on", 8'h00, {7'h00, aux_on});
        acc(1'b1, 7'h02, 8'h40, 8'h00);
        @(posedge core_clk);
        lock1 <= 1'b1;
        acc(1'b1, 7'h02, 8'h00, 8'h40);
        acc(1'b0, 7'h02, 8'h00, 8'h40);
        acc(1'b1, 7'h01, 8'hc0, 8'h18);
        chk("aux_mode", 8'h00, {6'h00, aux});
        chk("reset_n", 8'h01, {7'h00, rst_n});
        acc(1'b0, 7'h02, 8'h00, 8'h40);
    endtask : t_dev

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        errors = 0;
        total_checks = 0;
        rst_b = 1'b0;
        {dev_pin, init_m, rst_m, fs_m, ot, ov, ov_clr, wd, lock0, lock1, fail_act} = 11'h000;
        fpin = 1'b1;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        step(4);
        t_write();
        t_stop();
        t_ov();
        t_restart();
        t_hold_ot();
        t_soft();
        t_dev();
        final_report();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        final_report();
    end
endmodule : sbc_mode_hw_control_regs_tb_top
`default_nettype wire
